// ### rtl/msm_mapper.sv
`timescale 1ns/1ps
module msm_mapper (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Host audio, channels in order each sample period
  input wire logic in_valid,
  input wire logic [23:0] in_data,
  output logic in_ready,
  input wire msm_pkg::msm_mode_t mode,
  // Link slots
  output msm_pkg::msm_link_word_t link_word,
  output logic link_valid,
  input wire logic link_ready,
  // Clock clean-up
  input wire logic clk_external,
  input wire logic ref_in,
  output logic word_clk_out,
  output logic ref_locked
);

  msm_pkg::msm_state_t s;
  msm_pkg::msm_state_t next_s;
  logic [1:0] rst_q;
  logic rst_sync_n;
  logic [msm_pkg::SAMPLE_W-1:0] mem [64];
  logic [5:0] wr_addr;
  logic take;
  logic fifo_in_valid;
  logic fifo_in_ready;
  msm_pkg::msm_link_word_t fifo_in_word;
  logic fifo_out_valid;
  logic fifo_out_ready;
  msm_pkg::msm_link_word_t fifo_out_word;
  logic ref_edge;
  logic meas_ok;
  logic signed [11:0] diff;
  logic [10:0] psel;

  // Reset release through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_q[1];

  // Frame assembly, slot emission, output stage and clock clean-up
  always_comb begin
    next_s = s;
    take = in_valid && s.in_ready;
    wr_addr = msm_pkg::slot_addr(s.mode, s.ch, s.t);
    fifo_in_valid = (s.phase == msm_pkg::MSM_EMIT);
    fifo_in_word.dbl = (s.mode == msm_pkg::MSM_DOUBLE_FRAME);
    fifo_in_word.slot = s.emit;
    fifo_in_word.sample = mem[s.emit];
    fifo_out_ready = !s.out_valid || link_ready;
    unique case (s.phase)
      msm_pkg::MSM_FILL: begin
        // Mode only changes between frames, never mid-group
        if (s.ch == 6'h00 && s.t == 2'h0 && !take) begin
          next_s.mode = mode;
        end
        if (take) begin
          if (s.ch == msm_pkg::last_ch(s.mode)) begin
            next_s.ch = 6'h00;
            if (s.t == msm_pkg::last_t(s.mode)) begin
              next_s.t = 2'h0;
              next_s.emit = 6'h00;
              next_s.phase = msm_pkg::MSM_EMIT;
            end else begin
              next_s.t = 2'(s.t + 2'h1);
            end
          end else begin
            next_s.ch = 6'(s.ch + 6'h01);
          end
        end
      end
      msm_pkg::MSM_EMIT: begin
        if (fifo_in_ready) begin
          if (s.emit == msm_pkg::last_slot(s.mode)) begin
            next_s.phase = msm_pkg::MSM_FILL;
          end else begin
            next_s.emit = 6'(s.emit + 6'h01);
          end
        end
      end
    endcase
    // Host stalls while a frame drains; simpler than double buffering
    next_s.in_ready = (next_s.phase == msm_pkg::MSM_FILL);
    if (fifo_out_ready) begin
      next_s.out_valid = fifo_out_valid;
      if (fifo_out_valid) begin
        next_s.out_word = fifo_out_word;
      end
    end

    // Reference pin synchroniser and edge
    next_s.ref_s1 = ref_in;
    next_s.ref_s2 = s.ref_s1;
    next_s.ref_s3 = s.ref_s2;
    ref_edge = s.ref_s2 && !s.ref_s3;
    meas_ok = (s.meas >= msm_pkg::PERIOD_MIN) &&
              (s.meas <= msm_pkg::PERIOD_MAX);
    diff = $signed({1'b0, s.meas}) - $signed({1'b0, s.filt});
    if (ref_edge) begin
      next_s.meas = 11'h001;
      if (meas_ok) begin
        // Snap on first good edge for fast lock, then smooth
        if (!s.locked && s.lock_cnt == 3'h0) begin
          next_s.filt = s.meas;
        end else begin
          next_s.filt = 11'($signed({1'b0, s.filt}) + (diff >>> 2));
        end
        if (s.lock_cnt == msm_pkg::LOCK_EDGES) begin
          next_s.locked = 1'b1;
        end else begin
          next_s.lock_cnt = 3'(s.lock_cnt + 3'h1);
        end
      end else begin
        next_s.lock_cnt = 3'h0;
        next_s.locked = 1'b0;
      end
    end else if (s.meas <= msm_pkg::PERIOD_MAX) begin
      next_s.meas = 11'(s.meas + 11'h001);
    end else begin
      // Reference too slow or gone
      next_s.lock_cnt = 3'h0;
      next_s.locked = 1'b0;
    end

    // Regenerated word clock, realigned on each reference edge while locked with clk_external set
    psel = (s.locked && clk_external) ? s.filt : msm_pkg::PERIOD_INT;
    if (ref_edge && s.locked && clk_external) begin
      next_s.ph = 11'h000;
    end else if (s.ph >= 11'(psel - 11'h001)) begin
      next_s.ph = 11'h000;
    end else begin
      next_s.ph = 11'(s.ph + 11'h001);
    end
    next_s.wclk = (next_s.ph < (psel >> 1));
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s <= msm_pkg::MSM_STATE_RST;
    end else begin
      s <= next_s;
    end
  end

  // Frame store, written in host order, each sample at its link slot address
  always_ff @(posedge clk) begin
    if (take) begin
      mem[wr_addr] <= in_data;
    end
  end

  // Eight-word buffer between frame store and link
  msm_fifo #(
    .WIDTH($bits(msm_pkg::msm_link_word_t)),
    .DEPTH(msm_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_sync_n),
    .in_valid(fifo_in_valid),
    .in_data(fifo_in_word),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out_word),
    .out_ready(fifo_out_ready)
  );

  // Outputs straight from flops
  assign in_ready = s.in_ready;
  assign link_word = s.out_word;
  assign link_valid = s.out_valid;
  assign word_clk_out = s.wclk;
  assign ref_locked = s.locked;

  // Helper: last slot handed to the link
  logic [5:0] prev_slot;
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      prev_slot <= 6'h3F;
    end else if (link_valid && link_ready) begin
      prev_slot <= link_word.slot;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_n);

  property p_four_spread;
    (take && s.mode == msm_pkg::MSM_FOUR_WAY) |->
      wr_addr[1:0] == s.t && wr_addr[5:2] == s.ch[3:0];
  endproperty
  a_four_spread: assert property (p_four_spread)
    else $error("four-way slot placement wrong");

  property p_four_limit;
    (s.phase == msm_pkg::MSM_FILL && s.mode == msm_pkg::MSM_FOUR_WAY) |->
      s.ch <= msm_pkg::LAST_CH_FOUR;
  endproperty
  a_four_limit: assert property (p_four_limit)
    else $error("four-way channel beyond sixteen");

  property p_two_limit;
    (s.phase == msm_pkg::MSM_FILL && s.mode == msm_pkg::MSM_TWO_WAY) |->
      s.ch <= msm_pkg::LAST_CH_TWO && s.t <= 2'h1;
  endproperty
  a_two_limit: assert property (p_two_limit)
    else $error("two-way channel beyond thirty-two");

  property p_double_slots;
    (link_valid && link_word.dbl) |-> link_word.slot <= msm_pkg::LAST_CH_DOUBLE;
  endproperty
  a_double_slots: assert property (p_double_slots)
    else $error("double-rate frame slot beyond thirty-two");

  property p_lossless;
    take |=> mem[$past(wr_addr)] == $past(in_data);
  endproperty
  a_lossless: assert property (p_lossless)
    else $error("stored sample differs from input");

  property p_slot_order;
    (link_valid && link_ready && link_word.slot != 6'h00) |->
      link_word.slot == 6'(prev_slot + 6'h01);
  endproperty
  a_slot_order: assert property (p_slot_order)
    else $error("link slots out of order");

  property p_lock_range;
    ref_locked |-> s.filt >= msm_pkg::PERIOD_MIN &&
      s.filt <= msm_pkg::PERIOD_MAX;
  endproperty
  a_lock_range: assert property (p_lock_range)
    else $error("locked outside reference range");

  property p_align;
    (ref_edge && s.locked && clk_external) |=> s.ph == 11'h000 ##1
      s.ph == 11'h001;
  endproperty
  a_align: assert property (p_align)
    else $error("word clock not realigned to reference");

  property p_wclk_rise;
    $rose(word_clk_out) |-> s.ph == 11'h000;
  endproperty
  a_wclk_rise: assert property (p_wclk_rise)
    else $error("word clock rise off phase");

endmodule

// ### rtl/msm_pkg.sv
package msm_pkg;

  // Sample and clock figures
  localparam int SAMPLE_W = 24;
  localparam int CLK_HZ = 40000000;
  localparam int REF_MIN_HZ = 25000;
  localparam int REF_MAX_HZ = 200000;
  localparam int INT_RATE_HZ = 48000;
  localparam int FIFO_DEPTH = 8;

  // Longest period rounds down, shortest rounds up
  localparam logic [10:0] PERIOD_MAX = 11'(CLK_HZ / REF_MIN_HZ);
  localparam logic [10:0] PERIOD_MIN =
    11'((CLK_HZ + REF_MAX_HZ - 1) / REF_MAX_HZ);
  localparam logic [10:0] PERIOD_INT = 11'(CLK_HZ / INT_RATE_HZ);
  localparam logic [2:0] LOCK_EDGES = 3'h4;

  // Last usable channel per frame layout
  localparam logic [5:0] LAST_CH_SINGLE = 6'h3F;
  localparam logic [5:0] LAST_CH_TWO = 6'h1F;
  localparam logic [5:0] LAST_CH_FOUR = 6'h0F;
  localparam logic [5:0] LAST_CH_DOUBLE = 6'h1F;
  localparam logic [5:0] LAST_SLOT_BASE = 6'h3F;

  // Link layouts; no native quad-rate frame exists
  typedef enum logic [1:0] {
    MSM_SINGLE,
    MSM_TWO_WAY,
    MSM_FOUR_WAY,
    MSM_DOUBLE_FRAME
  } msm_mode_t;

  typedef enum logic [0:0] {
    MSM_FILL,
    MSM_EMIT
  } msm_phase_t;

  // One link slot on its way out
  typedef struct packed {
    logic dbl;
    logic [5:0] slot;
    logic [SAMPLE_W-1:0] sample;
  } msm_link_word_t;

  typedef struct packed {
    msm_phase_t phase;
    msm_mode_t mode;
    logic [5:0] ch;
    logic [1:0] t;
    logic [5:0] emit;
    logic in_ready;
    logic out_valid;
    msm_link_word_t out_word;
    logic ref_s1;
    logic ref_s2;
    logic ref_s3;
    logic [10:0] meas;
    logic [10:0] filt;
    logic [2:0] lock_cnt;
    logic locked;
    logic [10:0] ph;
    logic wclk;
  } msm_state_t;

  localparam msm_state_t MSM_STATE_RST = '{
    phase: MSM_FILL,
    mode: MSM_SINGLE,
    filt: PERIOD_INT,
    // Phase parked at wrap so the first word clock rise lands on phase 0
    ph: 11'(PERIOD_INT - 11'h001),
    default: '0
  };

  // Link slot of sample t of channel ch
  function automatic logic [5:0] slot_addr(msm_mode_t m, logic [5:0] ch,
                                           logic [1:0] t);
    case (m)
      MSM_TWO_WAY: slot_addr = {ch[4:0], t[0]};
      MSM_FOUR_WAY: slot_addr = {ch[3:0], t};
      default: slot_addr = ch;
    endcase
  endfunction

  function automatic logic [5:0] last_ch(msm_mode_t m);
    case (m)
      MSM_TWO_WAY: last_ch = LAST_CH_TWO;
      MSM_FOUR_WAY: last_ch = LAST_CH_FOUR;
      MSM_DOUBLE_FRAME: last_ch = LAST_CH_DOUBLE;
      default: last_ch = LAST_CH_SINGLE;
    endcase
  endfunction

  function automatic logic [1:0] last_t(msm_mode_t m);
    case (m)
      MSM_TWO_WAY: last_t = 2'h1;
      MSM_FOUR_WAY: last_t = 2'h3;
      default: last_t = 2'h0;
    endcase
  endfunction

  function automatic logic [5:0] last_slot(msm_mode_t m);
    last_slot = (m == MSM_DOUBLE_FRAME) ? LAST_CH_DOUBLE : LAST_SLOT_BASE;
  endfunction

endpackage

// ### rtl/msm_fifo.sv
`timescale 1ns/1ps
module msm_fifo #(
  parameter int WIDTH = 31,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } msm_fifo_state_t;

  msm_fifo_state_t s;
  msm_fifo_state_t next_s;
  logic [WIDTH-1:0] mem [DEPTH];
  logic full;
  logic empty;

  // Extra pointer bit tells full from empty
  always_comb begin
    next_s = s;
    empty = (s.wr == s.rd);
    full = (s.wr[AW] != s.rd[AW]) && (s.wr[AW-1:0] == s.rd[AW-1:0]);
    in_ready = !full;
    out_valid = !empty;
    out_data = mem[s.rd[AW-1:0]];
    if (in_valid && !full) begin
      next_s.wr = (AW+1)'(s.wr + 1'b1);
    end
    if (out_ready && !empty) begin
      next_s.rd = (AW+1)'(s.rd + 1'b1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Storage needs no reset
  always_ff @(posedge clk) begin
    if (in_valid && !full) begin
      mem[s.wr[AW-1:0]] <= in_data;
    end
  end

endmodule

// ### testbench/msm_link_sink.sv
`timescale 1ns/1ps
// Far-end receiver of link slots; can stall to push back on the FIFO
module msm_link_sink (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Link slots
  input wire msm_pkg::msm_link_word_t link_word,
  input wire logic link_valid,
  output logic link_ready,
  // Pacing and rate seen
  input wire logic slow,
  output logic rate_dbl
);
  logic [1:0] pace;

  // Slow pacing takes one word in four so the FIFO fills up
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pace <= 2'h0;
      rate_dbl <= 1'b0;
    end else begin
      pace <= pace + 2'h1;
      if (link_valid && link_ready) begin
        rate_dbl <= link_word.dbl;
      end
    end
  end

  // Never ready in reset, so nothing is taken early
  assign link_ready = rst_n && (!slow || pace == 2'h3);
endmodule

// ### testbench/madi_sample_multiplex_mapper_tb_top.sv
`timescale 1ns/1ps
module madi_sample_multiplex_mapper_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic in_valid = 1'b0;
  logic [23:0] in_data = 24'h000000;
  msm_pkg::msm_mode_t mode = msm_pkg::MSM_SINGLE;
  logic clk_external = 1'b0;
  logic ref_in = 1'b0;
  logic slow = 1'b0;
  logic in_ready, link_valid, link_ready, word_clk_out, ref_locked, rate_dbl;
  msm_pkg::msm_link_word_t link_word;
  msm_pkg::msm_link_word_t got[$];
  int n_mismatch = 0;
  int check_count = 0;
  int cycles = 0;
  real ref_half = 0.0;

  msm_mapper u_msm_mapper (
    .clk(clk), .rst_n(rst_n), .in_valid(in_valid), .in_data(in_data),
    .in_ready(in_ready), .mode(mode), .link_word(link_word),
    .link_valid(link_valid), .link_ready(link_ready),
    .clk_external(clk_external), .ref_in(ref_in),
    .word_clk_out(word_clk_out), .ref_locked(ref_locked)
  );

  msm_link_sink u_msm_link_sink (
    .clk(clk), .rst_n(rst_n), .link_word(link_word),
    .link_valid(link_valid), .link_ready(link_ready), .slow(slow),
    .rate_dbl(rate_dbl)
  );

  // 40 MHz system clock
  always #12.5 clk = ~clk;

  // Reference pin, unrelated in phase; parked low while stopped
  always begin
    if (ref_half > 0.0) begin
      #(ref_half) ref_in = ~ref_in;
    end else begin
      ref_in = 1'b0;
      #100;
    end
  end

  // Collect taken slots; cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (link_valid === 1'b1 && link_ready === 1'b1) begin
      got.push_back(link_word);
    end
    if (cycles == 90000) begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic check(logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Inputs change a fixed 2 ns after the rising edge
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  // Host order is t outer, channel inner; slots must come out ch*f+t
  task automatic run_frame(msm_pkg::msm_mode_t m, logic sl, int n, int f,
                           logic [7:0] tag);
    msm_pkg::msm_link_word_t e;
    int w;
    got.delete();
    slow = sl;
    mode = m;
    // Mode is latched only on an idle cycle before the first word
    step(1);
    for (int k = 0; k < n * f; k++) begin
      in_valid = 1'b1;
      in_data = {tag, 8'(k % n), 8'(k / n)};
      w = 0;
      while (in_ready !== 1'b1 && w < 3000) begin
        step(1);
        w++;
      end
      step(1);
    end
    in_valid = 1'b0;
    step(1);
    check(32'(in_ready), 32'h0);
    w = 0;
    while (got.size() < n * f && w < 3000) begin
      step(1);
      w++;
    end
    step(40);
    check(32'(got.size()), 32'(n * f));
    for (int j = 0; j < n * f && j < got.size(); j++) begin
      e.dbl = (m == msm_pkg::MSM_DOUBLE_FRAME);
      e.slot = 6'(j);
      e.sample = {tag, 8'(j / f), 8'(j % f)};
      check(32'(got[j].sample), 32'(e.sample));
      check(32'(got[j].slot), 32'(e.slot));
      check(32'(got[j].dbl), 32'(e.dbl));
    end
  endtask

  task automatic t_single();
    run_frame(msm_pkg::MSM_SINGLE, 1'b0, 64, 1, 8'h5A);
  endtask

  task automatic t_two();
    run_frame(msm_pkg::MSM_TWO_WAY, 1'b0, 32, 2, 8'hC3);
  endtask

  // Far end stalls so the FIFO fills and refuses
  task automatic t_four();
    run_frame(msm_pkg::MSM_FOUR_WAY, 1'b1, 16, 4, 8'h96);
  endtask

  task automatic t_double();
    run_frame(msm_pkg::MSM_DOUBLE_FRAME, 1'b0, 32, 1, 8'h3E);
    check(32'(rate_dbl), 32'h1);
  endtask

  // Lag from reference rise to word clock rise, then one full period
  task automatic wclk_measure(logic use_ref, output int lag, output int p);
    lag = 0;
    p = 0;
    if (use_ref) @(posedge ref_in);
    else wait (word_clk_out === 1'b0);
    // Sample off the edge so the design's new value has settled
    while (word_clk_out !== 1'b1 && lag < 4000) begin
      step(1);
      lag++;
    end
    while (word_clk_out === 1'b1 && p < 4000) begin
      step(1);
      p++;
    end
    while (word_clk_out !== 1'b1 && p < 4000) begin
      step(1);
      p++;
    end
  endtask

  // Near 200 kHz reference, then a single step down to near 25 kHz
  task automatic t_ref_track();
    int lag, p;
    clk_external = 1'b1;
    ref_half = 2505.0;
    step(2600);
    check(32'(ref_locked), 32'h1);
    wclk_measure(1'b1, lag, p);
    check(32'(p >= 197 && p <= 203), 32'h1);
    ref_half = 19950.0;
    step(38400);
    check(32'(ref_locked), 32'h1);
    wclk_measure(1'b1, lag, p);
    check(32'(p >= 1593 && p <= 1599), 32'h1);
    check(32'(lag <= 8), 32'h1);
  endtask

  // Too fast a reference loses lock; internal rate still reaches output
  task automatic t_ref_refuse();
    int lag, p;
    ref_half = 1250.0;
    step(1500);
    check(32'(ref_locked), 32'h0);
    clk_external = 1'b0;
    ref_half = 0.0;
    step(2000);
    wclk_measure(1'b0, lag, p);
    check(32'(p), 32'(msm_pkg::PERIOD_INT));
  endtask

  initial begin
    step(3);
    check(32'(link_valid), 32'h0);
    check(32'(in_ready), 32'h0);
    rst_n = 1'b1;
    step(4);
    t_single();
    t_two();
    t_four();
    t_double();
    t_ref_track();
    t_ref_refuse();
    conclude();
  end
endmodule
